// ==== rtl/pwm_master_time_base.sv ====
// master time base of the PWM module with its APB register file
//
// Added by the designer: the APB register port and the register offsets.
`include "pwm_tb_map.svh"
module pwm_master_time_base #(
    parameter int GEN_COUNT = 4
) (
    input wire logic ref_clk, // 250 MHz core clock
    input wire logic srst, // synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic cpu_idle, // processor in idle mode
    input wire logic center_aligned, // generators in center-aligned mode
    input wire logic [GEN_COUNT-1:0] gen_enable, // per-generator enable
    input wire logic sync_input_one, // external sync pin one
    input wire logic sync_input_two, // external sync pin two
    output logic sync_output, // sync pulse pin
    output logic sync_output_oe, // sync pin driver enable
    output logic special_event_trigger, // one-cycle trigger pulse
    output logic special_event_irq, // interrupt request level
    output logic [GEN_COUNT-1:0] gen_cycle_start, // cycle start per gen
    output logic [2*GEN_COUNT-1:0] pin_pair_active // high/low pins live
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pwm_tb_pkg::tb_ctrl_t ctrl;
    pwm_tb_pkg::tb_ctrl_t next_ctrl;
    logic [2:0] input_clock_divider;
    logic [2:0] next_divider;
    logic [15:0] master_period;
    logic [15:0] next_period;
    logic [15:0] active_period;
    logic [15:0] next_active;
    logic [15:0] special_event_compare;
    logic [15:0] next_compare;
    logic [15:0] master_time_base_counter;
    logic [15:0] next_counter;
    logic [3:0] post_count;
    logic [3:0] next_post;
    logic [2:0] fine_count;
    logic [2:0] next_fine;
    logic sync_active_d;
    logic next_sync_d;
    pwm_tb_pkg::tb_event_t evt;
    logic next_trigger;
    logic next_irq;
    logic next_sync_out;
    logic [GEN_COUNT-1:0] next_gen_start;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    logic tick;
    logic halted;
    logic advance;
    logic [1:0] sync_levels;
    logic sync_selected;
    logic sync_active;
    logic sync_hit;
    logic wr_access;
    logic ctrl_wr;
    logic [15:0] wr_value;
    logic mapped;

    // ------------------------------------------------------------------
    // pin inputs and prescaler
    // ------------------------------------------------------------------
    pin_sync3 #(
        .WIDTH(2)
    ) u_sync_in (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_in({sync_input_two, sync_input_one}),
        .level_out(sync_levels)
    );

    clk_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .srst(srst),
        .run(ctrl.module_enable && !halted),
        .divide_code(input_clock_divider),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // time base control
    // ------------------------------------------------------------------
    always_comb begin
        halted = ctrl.idle_stop && cpu_idle;
        // center-aligned counts one step per eight ticks
        advance = tick && (!center_aligned
            || fine_count == `TB_CENTER_STEPS);
        // reserved source codes pick no input
        case (ctrl.sync_source_select)
            pwm_tb_pkg::SRC_INPUT_ONE: sync_selected = sync_levels[0];
            pwm_tb_pkg::SRC_INPUT_TWO: sync_selected = sync_levels[1];
            default: sync_selected = 1'b0;
        endcase
        sync_active = sync_selected ^ ctrl.sync_polarity;
        sync_hit = ctrl.external_sync_enable && sync_active
            && !sync_active_d && ctrl.module_enable && !halted;
        next_sync_d = sync_active;

        next_counter = master_time_base_counter;
        next_post = post_count;
        next_fine = fine_count;
        evt = '0;
        if (!ctrl.module_enable) begin
            next_counter = 16'h0000;
            next_post = 4'h0;
            next_fine = 3'h0;
        end else if (sync_hit) begin
            next_counter = 16'h0000;
            next_fine = 3'h0;
            evt.restart = 1'b1;
        end else if (tick) begin
            next_fine = center_aligned ? fine_count + 3'h1 : 3'h0;
            if (advance) begin
                evt.compare_match = (master_time_base_counter
                    == special_event_compare);
                if (master_time_base_counter >= active_period) begin
                    next_counter = 16'h0000;
                    evt.restart = 1'b1;
                end else begin
                    next_counter = master_time_base_counter + 16'h0001;
                end
            end
        end

        next_trigger = 1'b0;
        if (evt.compare_match) begin
            if (post_count >= ctrl.special_event_postscale) begin
                next_trigger = 1'b1;
                next_post = 4'h0;
            end else begin
                next_post = post_count + 4'h1;
            end
        end

        // deferred period loads only at the restart of a cycle or while the module is disabled
        next_active = active_period;
        if (ctrl.immediate_period_update || !ctrl.module_enable) begin
            next_active = master_period;
        end else if (evt.restart) begin
            next_active = master_period;
        end

        next_sync_out = ctrl.sync_polarity;
        if (ctrl.sync_output_enable && evt.restart) begin
            next_sync_out = !ctrl.sync_polarity;
        end

        for (int g = 0; g < GEN_COUNT; g++) begin
            next_gen_start[g] = evt.restart && gen_enable[g];
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    always_comb begin
        wr_access = psel && penable && pready && pwrite;
        wr_value = pwdata[15:0];
        ctrl_wr = wr_access && (paddr == `TB_CTRL_OFFSET);

        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl = pwm_tb_pkg::tb_ctrl_t'(
                (wr_value & `TB_CTRL_WMASK)
                | (16'(ctrl) & ~`TB_CTRL_WMASK));
        end
        // software may only clear the flag; a new trigger wins
        next_ctrl.special_event_status = next_trigger
            || (ctrl.special_event_status
                && !(ctrl_wr && !wr_value[`TB_BIT_STATUS]));
        next_ctrl.unused_hi = 1'b0;
        next_ctrl.unused_lo = 1'b0;

        next_irq = next_ctrl.special_event_status
            && next_ctrl.special_event_irq_enable;

        next_divider = input_clock_divider;
        next_period = master_period;
        next_compare = special_event_compare;
        if (wr_access && paddr == `TB_CLKDIV_OFFSET) begin
            next_divider = wr_value[2:0];
        end
        if (wr_access && paddr == `TB_PERIOD_OFFSET) begin
            // out-of-range loads are clamped to the legal span
            if (wr_value < `TB_PERIOD_MIN) begin
                next_period = `TB_PERIOD_MIN;
            end else if (wr_value > `TB_PERIOD_MAX) begin
                next_period = `TB_PERIOD_MAX;
            end else begin
                next_period = wr_value;
            end
        end
        if (wr_access && paddr == `TB_COMPARE_OFFSET) begin
            next_compare = wr_value & `TB_COMPARE_MASK;
        end

        // zero-wait answer: ready is raised for the access phase only
        mapped = 1'b1;
        next_prdata = 32'h0000_0000;
        if (paddr == `TB_CTRL_OFFSET) begin
            next_prdata = {16'h0000, 16'(ctrl)};
        end else if (paddr == `TB_CLKDIV_OFFSET) begin
            next_prdata = {29'h0000_0000, input_clock_divider};
        end else if (paddr == `TB_PERIOD_OFFSET) begin
            next_prdata = {16'h0000, master_period};
        end else if (paddr == `TB_COMPARE_OFFSET) begin
            next_prdata = {16'h0000, special_event_compare};
        end else if (paddr == `TB_COUNT_OFFSET) begin
            next_prdata = {16'h0000, master_time_base_counter};
        end else begin
            mapped = 1'b0;
        end
        next_pready = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        if (!(psel && !penable) || pwrite) begin
            next_prdata = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= pwm_tb_pkg::tb_ctrl_t'(`TB_CTRL_RESET);
            input_clock_divider <= `TB_CLKDIV_RESET;
            master_period <= `TB_PERIOD_RESET;
            active_period <= `TB_PERIOD_RESET;
            special_event_compare <= `TB_COMPARE_RESET;
            master_time_base_counter <= 16'h0000;
            post_count <= 4'h0;
            fine_count <= 3'h0;
            sync_active_d <= 1'b0;
            special_event_trigger <= 1'b0;
            special_event_irq <= 1'b0;
            sync_output <= 1'b0;
            sync_output_oe <= 1'b0;
            gen_cycle_start <= '0;
            pin_pair_active <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            input_clock_divider <= next_divider;
            master_period <= next_period;
            active_period <= next_active;
            special_event_compare <= next_compare;
            master_time_base_counter <= next_counter;
            post_count <= next_post;
            fine_count <= next_fine;
            sync_active_d <= next_sync_d;
            special_event_trigger <= next_trigger;
            special_event_irq <= next_irq;
            sync_output <= next_sync_out;
            sync_output_oe <= ctrl.sync_output_enable;
            gen_cycle_start <= next_gen_start;
            pin_pair_active <= {2{gen_enable & {GEN_COUNT{
                ctrl.module_enable}}}};
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ==== pkg/pwm_tb_map.svh ====
// register offsets, field positions, reset values and limits of the time base
`ifndef PWM_TB_MAP_SVH
`define PWM_TB_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TB_CTRL_OFFSET 12'h000
`define TB_CLKDIV_OFFSET 12'h004
`define TB_PERIOD_OFFSET 12'h008
`define TB_COMPARE_OFFSET 12'h00C
`define TB_COUNT_OFFSET 12'h010

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define TB_BIT_ENABLE 15
`define TB_BIT_UNUSED_HI 14
`define TB_BIT_IDLE_STOP 13
`define TB_BIT_STATUS 12
`define TB_BIT_IRQ_EN 11
`define TB_BIT_IMMEDIATE 10
`define TB_BIT_POLARITY 9
`define TB_BIT_SYNC_OEN 8
`define TB_BIT_SYNC_EN 7
`define TB_BIT_UNUSED_LO 6
`define TB_CTRL_WMASK 16'hBFBF

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define TB_CTRL_RESET 16'h0000
`define TB_CLKDIV_RESET 3'h0
`define TB_CLKDIV_RESERVED 3'h7
`define TB_PERIOD_RESET 16'hFFF8
`define TB_PERIOD_MIN 16'h0010
`define TB_PERIOD_MAX 16'hFFF8
`define TB_COMPARE_RESET 16'h0000
`define TB_COMPARE_MASK 16'hFFF8
`define TB_CENTER_STEPS 3'h7

`endif

// ==== pkg/pwm_tb_pkg.sv ====
// types shared by the master time-base files
package pwm_tb_pkg;

    // bit 15 first: the struct lines up with the control word
    typedef struct packed {
        logic module_enable;
        logic unused_hi;
        logic idle_stop;
        logic special_event_status;
        logic special_event_irq_enable;
        logic immediate_period_update;
        logic sync_polarity;
        logic sync_output_enable;
        logic external_sync_enable;
        logic unused_lo;
        logic [1:0] sync_source_select;
        logic [3:0] special_event_postscale;
    } tb_ctrl_t;

    typedef enum logic [1:0] {
        SRC_INPUT_ONE = 2'h0,
        SRC_INPUT_TWO = 2'h1
    } sync_src_t;

    typedef struct packed {
        logic restart;
        logic compare_match;
    } tb_event_t;

endpackage

// ==== rtl/pin_sync3.sv ====
// three-stage pin synchroniser with agreement filter
module pin_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic ref_clk, // core clock
    input wire logic srst, // synchronous reset, active high
    input wire logic [WIDTH-1:0] pin_in, // raw pin levels
    output logic [WIDTH-1:0] level_out // filtered level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // a change is taken only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i]
                                                     : level_out[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_out <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end

endmodule

// ==== rtl/clk_prescaler.sv ====
// power-of-two prescaler giving a one-cycle tick
module clk_prescaler (
    input wire logic ref_clk, // core clock
    input wire logic srst, // synchronous reset, active high
    input wire logic run, // count while high
    input wire logic [2:0] divide_code, // divide by 2**code, reserved code 7 by 64 as code 6
    output logic tick // one-cycle enable pulse
);

    logic [5:0] count;
    logic [5:0] next_count;
    logic [5:0] terminal;
    logic next_tick;

    // reserved code 111 cuts to 3F: it behaves as the largest divider
    always_comb begin
        terminal = 6'((7'h01 << divide_code) - 7'h01);
        next_tick = 1'b0;
        next_count = count;
        if (!run) begin
            next_count = 6'h00;
        end else if (count >= terminal) begin
            next_count = 6'h00;
            next_tick = 1'b1;
        end else begin
            next_count = count + 6'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= 6'h00;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

endmodule

// ==== bench/pwm_master_time_base_sva.sv ====
// assertion checker bound to the pwm master time base
`include "pwm_tb_map.svh"
module time_base_checker #(
    parameter int GEN_COUNT = 4
) (
    input wire logic ref_clk, // core clock
    input wire logic srst, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [GEN_COUNT-1:0] gen_enable, // generator enables
    input wire logic sync_output, // sync pulse pin
    input wire logic sync_output_oe, // sync pin enable
    input wire logic special_event_trigger, // trigger pulse
    input wire logic special_event_irq, // interrupt request
    input wire logic [GEN_COUNT-1:0] gen_cycle_start, // cycle starts
    input wire logic [2*GEN_COUNT-1:0] pin_pair_active // live pin pairs
);
    // ----------------------------------------------------------------
    // shadow of the control bits software wrote
    // ----------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pready && pwrite
        && paddr == `TB_CTRL_OFFSET;
    always_comb begin
        next_ctrl = wr_ctrl ? pwdata[15:0] : ctrl;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= 16'h0000;
        end else begin
            ctrl <= next_ctrl;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    AST_PREADY_PULSE: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready is not one access cycle");
    AST_UNMAPPED_ERR: assert property (
        pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > `TB_COUNT_OFFSET))
        else $error("pslverr does not match address map");
    AST_DISABLED_QUIET: assert property (
        !ctrl[`TB_BIT_ENABLE] ##1 !ctrl[`TB_BIT_ENABLE]
        |-> !special_event_trigger && gen_cycle_start == '0)
        else $error("event while module disabled");
    AST_IRQ_GATED: assert property (
        !ctrl[`TB_BIT_IRQ_EN] ##1 !ctrl[`TB_BIT_IRQ_EN]
        |-> !special_event_irq)
        else $error("interrupt while its enable is clear");
    AST_TRIG_RAISES_IRQ: assert property (
        special_event_trigger && ctrl[`TB_BIT_IRQ_EN]
        |-> ##[0:1] special_event_irq)
        else $error("enabled trigger gave no interrupt");
    AST_OE_FOLLOWS: assert property (
        sync_output_oe == $past(ctrl[`TB_BIT_SYNC_OEN]))
        else $error("sync pin enable does not follow control");
    AST_SYNC_QUIET: assert property (
        !ctrl[`TB_BIT_SYNC_OEN] |=> sync_output == $past(ctrl[9]))
        else $error("sync output left its inactive level");
    AST_SYNC_PULSE: assert property (
        sync_output != ctrl[9] && $stable(ctrl[9])
        |=> sync_output == ctrl[9])
        else $error("sync output pulse longer than one cycle");
    AST_PINS_PAIR: assert property (
        pin_pair_active == {2{$past(gen_enable)
        & {GEN_COUNT{$past(ctrl[`TB_BIT_ENABLE])}}}})
        else $error("pin pairs do not follow generator enables");
    AST_START_GATED: assert property (
        (gen_cycle_start & ~$past(gen_enable)) == '0)
        else $error("cycle start on a disabled generator");
endmodule

bind pwm_master_time_base time_base_checker #(.GEN_COUNT(GEN_COUNT))
    u_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .gen_enable(gen_enable), .sync_output(sync_output),
    .sync_output_oe(sync_output_oe),
    .special_event_trigger(special_event_trigger),
    .special_event_irq(special_event_irq),
    .gen_cycle_start(gen_cycle_start),
    .pin_pair_active(pin_pair_active));

// ==== bench/sync_src_model.sv ====
// external sync source model for both sync pins
module sync_src_model (
    input wire logic ref_clk, // paces the pulse width
    input wire logic active_low, // pins idle high and pulse low
    input wire logic [1:0] fire, // pulse request, bit 0 for pin one
    output logic sync_input_one, // sync pin one
    output logic sync_input_two // sync pin two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left [2] = '{3'h0, 3'h0};
    // five cycles wide so the pin filter agrees on every pulse
    always @(posedge ref_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (fire[i]) begin
                left[i] <= 3'h5;
            end else if (left[i] != 3'h0) begin
                left[i] <= left[i] - 3'h1;
            end
        end
    end
    assign sync_input_one = active_low ^ (left[0] != 3'h0);
    assign sync_input_two = active_low ^ (left[1] != 3'h0);
endmodule

// ==== bench/test_pwm_master_time_base.sv ====
// self-checking testbench of the pwm master time base
`include "pwm_tb_map.svh"
module test_pwm_master_time_base;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cpu_idle = 1'b0, center_aligned = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0] gen_enable = 4'hF, gen_cycle_start;
    logic pready, pslverr, sync_input_one, sync_input_two, sync_output;
    logic sync_output_oe, special_event_trigger, special_event_irq;
    logic [7:0] pin_pair_active;
    logic pol_low = 1'b0, sel = 1'b0, ev;
    logic [1:0] fire = 2'h0;
    int miscompares = 0, checks_done = 0, cycles = 0;
    assign ev = sel ? special_event_trigger : gen_cycle_start[0];
    pwm_master_time_base u_dut (.ref_clk(ref_clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_idle(cpu_idle),
        .center_aligned(center_aligned), .gen_enable(gen_enable),
        .sync_input_one(sync_input_one), .sync_input_two(sync_input_two),
        .sync_output(sync_output), .sync_output_oe(sync_output_oe),
        .special_event_trigger(special_event_trigger),
        .special_event_irq(special_event_irq),
        .gen_cycle_start(gen_cycle_start),
        .pin_pair_active(pin_pair_active));
    sync_src_model u_src (.ref_clk(ref_clk), .active_low(pol_low),
        .fire(fire), .sync_input_one(sync_input_one),
        .sync_input_two(sync_input_two));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [15:0] d, output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 16'h0000, r, e);
    endtask
    // cycles between two events; waits for the first one
    task automatic gap(output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
        end while (ev !== 1'b1);
        do begin
            @(negedge ref_clk);
            c++;
        end while (ev !== 1'b1);
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd(`TB_PERIOD_OFFSET, r);
        chk("period reset", r, 32'h0000_FFF8);
        rd(`TB_CTRL_OFFSET, r);
        chk("control reset", r, 32'h0000_0000);
        wr(`TB_CTRL_OFFSET, 16'h7FFF);
        rd(`TB_CTRL_OFFSET, r);
        chk("control readback", r, 32'h0000_2FBF);
        wr(`TB_CTRL_OFFSET, 16'h0000);
        wr(`TB_COMPARE_OFFSET, 16'hFFFF);
        rd(`TB_COMPARE_OFFSET, r);
        chk("compare low bits", r, 32'h0000_FFF8);
        wr(`TB_PERIOD_OFFSET, 16'h0004);
        rd(`TB_PERIOD_OFFSET, r);
        chk("period floor", r, 32'h0000_0010);
        apb(1'b0, 12'h020, 16'h0000, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_count;
        int c;
        logic [31:0] r;
        gen_enable <= 4'h5;
        sel <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(`TB_CTRL_OFFSET, 16'h0000);
            center_aligned <= (i == 2);
            wr(`TB_CLKDIV_OFFSET, (i == 1) ? 16'h0001 : 16'h0000);
            wr(`TB_PERIOD_OFFSET, 16'h0010);
            wr(`TB_CTRL_OFFSET, 16'h8000);
            gap(c);
            chk("cycle length", c, (i == 0) ? 17 : (i == 1) ? 34 : 136);
        end
        chk("pin pairs", pin_pair_active, 32'h55);
        wr(`TB_CTRL_OFFSET, 16'h0000);
        center_aligned <= 1'b0;
        rd(`TB_COUNT_OFFSET, r);
        chk("stopped count", r, 32'h0);
        $display("test count done");
    endtask
    task automatic t_events;
        int c;
        logic [31:0] r;
        sel <= 1'b1;
        wr(`TB_COMPARE_OFFSET, 16'h0008);
        for (int ps = 0; ps < 16; ps += 15) begin
            wr(`TB_CTRL_OFFSET, 16'h0000);
            wr(`TB_CTRL_OFFSET, 16'h8800 | ps[15:0]);
            gap(c);
            chk("trigger spacing", c, (ps + 1) * 17);
            @(negedge ref_clk);
            chk("irq raised", special_event_irq, 32'h1);
            rd(`TB_CTRL_OFFSET, r);
            chk("status set", r[12], 32'h1);
            wr(`TB_CTRL_OFFSET, 16'h8800 | ps[15:0]);
            repeat (2) @(negedge ref_clk);
            chk("irq cleared", special_event_irq, 32'h0);
        end
        wr(`TB_CTRL_OFFSET, 16'h0000);
        wr(`TB_CTRL_OFFSET, 16'h8000);
        gap(c);
        @(negedge ref_clk);
        chk("irq masked", special_event_irq, 32'h0);
        rd(`TB_CTRL_OFFSET, r);
        chk("masked status", r[12], 32'h1);
        $display("test events done");
    endtask
    task automatic t_idle;
        logic [31:0] a, b;
        cpu_idle <= 1'b1;
        wr(`TB_CTRL_OFFSET, 16'h0000);
        wr(`TB_CTRL_OFFSET, 16'hA000);
        rd(`TB_COUNT_OFFSET, a);
        rd(`TB_COUNT_OFFSET, b);
        chk("halted in idle", b, a);
        wr(`TB_CTRL_OFFSET, 16'h0000);
        wr(`TB_CTRL_OFFSET, 16'h8000);
        rd(`TB_COUNT_OFFSET, a);
        rd(`TB_COUNT_OFFSET, b);
        chk("runs in idle", a != b, 32'h1);
        cpu_idle <= 1'b0;
        $display("test idle done");
    endtask
    task automatic t_sync;
        logic pol, en, src, hit, seen;
        int c;
        sel <= 1'b0;
        wr(`TB_CTRL_OFFSET, 16'h0000);
        wr(`TB_PERIOD_OFFSET, 16'h0100);
        for (int k = 0; k < 3; k++) begin
            pol = (k == 1);
            en = (k != 2);
            src = (k == 1);
            wr(`TB_CTRL_OFFSET, 16'h0000);
            pol_low <= pol;
            wr(`TB_CTRL_OFFSET, {6'h20, pol, 1'b1, en, 2'h0, src, 4'h0});
            gap(c);
            repeat (40) @(negedge ref_clk);
            chk("sync idle level", sync_output, pol);
            chk("sync pin enable", sync_output_oe, 32'h1);
            @(posedge ref_clk);
            fire <= src ? 2'h2 : 2'h1;
            @(posedge ref_clk);
            fire <= 2'h0;
            hit = 1'b0;
            seen = 1'b0;
            repeat (20) begin
                @(negedge ref_clk);
                hit |= (ev === 1'b1);
                seen |= (sync_output !== pol);
            end
            chk("sync restart", hit, en);
            chk("sync out pulse", seen, en);
        end
        $display("test sync done");
    endtask
    // ----------------------------------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_count();
        t_events();
        t_idle();
        t_sync();
        close_out();
    end
endmodule
